// *** hdl/sdram_bank_param_regs.sv ***
// configuration register bank for SDRAM bank timing and geometry
// assumes config-space accesses arrive as one-cycle read/write strobes
//
// Summary of operation
// R1: bank-0 row cycle time in ns sits in bits 7:0, default 70
// R2: bank-0 second aux timing register resets to 0x00000046
// R3: bank-0 error code in bits 7:0, resets to zero
// R4: bank-1 row address bit count kept in bits 31:28
// R5: bank-1 data width in bits 31:16, byte 7 high, byte 6 low
// R6: firmware zeroes upper width byte for modules under 256 bits
// R7: programmed width is checked against installed memory width
// R8: physical bank count on module in bits 15:8, not internal banks
// R9: column address bit count in bits 3:0
// R10: minimum clock period at highest CAS latency in bits 15:8
// R11: cycle byte is whole ns nibble plus tenths nibble
// R12: refresh rate and type byte held in bits 7:0 as encoded
// R13: reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_param_regs (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire sdram_bank_param_pkg::cfg_req_s req_i,
  input wire logic [15:0] installed_width_i,
  input wire logic [7:0] error_code_i,
  input wire logic error_load_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic width_match_o,
  output logic [7:0] cycle_tenths_o,
  output sdram_bank_param_pkg::bank_params_s params_o
);
  import sdram_bank_param_pkg::*;
  `include "sdram_bank_param_consts.svh"

  logic [31:0] aux_two, err_code, geo_one, geo_two, cyc_time, refresh;
  logic [31:0] next_aux_two, next_err_code, next_geo_one, next_geo_two;
  logic [31:0] next_cyc_time, next_refresh;
  logic [31:0] next_rdata;
  logic next_rvalid, next_width_match;
  logic [7:0] tenths;

  // masked writes; hardware error load wins over a firmware write
  always_comb begin
    next_aux_two = aux_two;
    next_err_code = err_code;
    next_geo_one = geo_one;
    next_geo_two = geo_two;
    next_cyc_time = cyc_time;
    next_refresh = refresh;
    if (req_i.wr_en) begin
      case (req_i.addr)
        `OFS_BANK0_AUX_TIMING_TWO: begin
          next_aux_two = req_i.wdata & `MASK_AUX_TIMING_TWO; // R1 R13
        end
        `OFS_BANK0_ERROR_CODE: begin
          next_err_code = req_i.wdata & `MASK_ERROR_CODE; // R3 R13
        end
        `OFS_BANK1_GEOMETRY_ONE: begin
          next_geo_one = req_i.wdata & `MASK_GEOMETRY_ONE; // R4 R13
        end
        `OFS_BANK1_GEOMETRY_TWO: begin
          next_geo_two = req_i.wdata & `MASK_GEOMETRY_TWO; // R5 R8 R9
        end
        `OFS_BANK1_CYCLE_TIME: begin
          next_cyc_time = req_i.wdata & `MASK_CYCLE_TIME; // R10 R13
        end
        `OFS_BANK1_REFRESH_SETTING: begin
          next_refresh = req_i.wdata & `MASK_REFRESH; // R12 R13
        end
        default: begin
          next_aux_two = aux_two;
        end
      endcase
    end
    // controller-reported error beats a same-cycle write
    if (error_load_i) begin
      next_err_code = {24'h00_0000, error_code_i}; // R3
    end
  end

  // read mux; unmapped offsets return zero
  always_comb begin
    next_rvalid = req_i.rd_en;
    next_rdata = 32'h0000_0000;
    if (req_i.rd_en) begin
      case (req_i.addr)
        `OFS_BANK0_AUX_TIMING_TWO: next_rdata = aux_two;
        `OFS_BANK0_ERROR_CODE: next_rdata = err_code;
        `OFS_BANK1_GEOMETRY_ONE: next_rdata = geo_one;
        `OFS_BANK1_GEOMETRY_TWO: next_rdata = geo_two;
        `OFS_BANK1_CYCLE_TIME: next_rdata = cyc_time;
        `OFS_BANK1_REFRESH_SETTING: next_rdata = refresh;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // width check against the installed module, registered
  always_comb begin
    next_width_match = (geo_two[31:16] == installed_width_i); // R7 R5
  end

  // register stage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aux_two <= `RST_BANK0_AUX_TIMING_TWO; // R2
      err_code <= `RST_ZERO;
      geo_one <= `RST_ZERO;
      geo_two <= `RST_ZERO;
      cyc_time <= `RST_ZERO;
      refresh <= `RST_ZERO;
      rdata_o <= 32'h0000_0000;
      rvalid_o <= 1'b0;
      width_match_o <= 1'b0;
      cycle_tenths_o <= 8'h00;
    end else begin
      aux_two <= next_aux_two;
      err_code <= next_err_code;
      geo_one <= next_geo_one;
      geo_two <= next_geo_two;
      cyc_time <= next_cyc_time;
      refresh <= next_refresh;
      rdata_o <= next_rdata;
      rvalid_o <= next_rvalid;
      width_match_o <= next_width_match;
      cycle_tenths_o <= tenths;
    end
  end

  // decode the cycle byte for the timing logic downstream
  cycle_time_decode u_cyc (
    .code_i(cyc_time[15:8]),
    .tenths_o(tenths)
  );

  // field view handed to the controller
  always_comb begin
    params_o.row_cycle_ns = aux_two[7:0]; // R1
    params_o.row_addr_bits = geo_one[31:28]; // R4
    params_o.module_data_width = geo_two[31:16]; // R5
    params_o.physical_bank_count = geo_two[15:8]; // R8
    params_o.col_addr_bits = geo_two[3:0]; // R9
    params_o.min_period_at_max_latency = cyc_time[15:8]; // R10
    params_o.refresh_rate_type = refresh[7:0]; // R12
  end
endmodule
`default_nettype wire

// *** hdl/sdram_bank_param_consts.svh ***
// offsets, field positions, reset values for the bank parameter registers
// assumes inclusion by bare name from the regs and decode modules
`ifndef SDRAM_BANK_PARAM_CONSTS_SVH
`define SDRAM_BANK_PARAM_CONSTS_SVH
`define OFS_BANK0_AUX_TIMING_TWO 8'ha4
`define OFS_BANK0_ERROR_CODE 8'ha8
`define OFS_BANK1_GEOMETRY_ONE 8'hb0
`define OFS_BANK1_GEOMETRY_TWO 8'hb4
`define OFS_BANK1_CYCLE_TIME 8'hb8
`define OFS_BANK1_REFRESH_SETTING 8'hbc
`define RST_BANK0_AUX_TIMING_TWO 32'h0000_0046
`define RST_ZERO 32'h0000_0000
// writable masks: reserved bits never store
`define MASK_AUX_TIMING_TWO 32'h0000_00ff
`define MASK_ERROR_CODE 32'h0000_00ff
`define MASK_GEOMETRY_ONE 32'hf000_0000
`define MASK_GEOMETRY_TWO 32'hffff_ff0f
`define MASK_CYCLE_TIME 32'h0000_ff00
`define MASK_REFRESH 32'h0000_00ff
// field positions
`define ROW_BITS_LSB 28
`define WIDTH_LSB 16
`define PBANK_LSB 8
`define CYCLE_LSB 8
`define NS_PER_UNIT 8'h0a
`endif

// *** hdl/sdram_bank_param_pkg.sv ***
// types shared by the bank parameter register block
// assumes the consts header is on the include path
package sdram_bank_param_pkg;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cfg_req_s;
  typedef struct packed {
    logic [7:0] row_cycle_ns;
    logic [3:0] row_addr_bits;
    logic [15:0] module_data_width;
    logic [7:0] physical_bank_count;
    logic [3:0] col_addr_bits;
    logic [7:0] min_period_at_max_latency;
    logic [7:0] refresh_rate_type;
  } bank_params_s;
endpackage

// *** hdl/cycle_time_decode.sv ***
// decodes a whole/tenths nanosecond byte into tenths of a nanosecond
// assumes a byte whose high nibble is ns and low nibble tenths
`timescale 1ns/1ps
`default_nettype none
module cycle_time_decode (
  input wire logic [7:0] code_i,
  output logic [7:0] tenths_o
);
  `include "sdram_bank_param_consts.svh"
  // whole ns times ten plus tenths; max 15*10+15 fits eight bits
  always_comb begin
    tenths_o = 8'(code_i[7:4] * `NS_PER_UNIT) + {4'h0, code_i[3:0]}; // R11
  end
endmodule
`default_nettype wire

// *** sim/spd_module_model.sv ***
// stand-in for a fitted module's presence-detect width bytes
// assumes the bench ties width_o to the installed width input
`timescale 1ns/1ps
`default_nettype none
module spd_module_model #(parameter logic [15:0] WIDTH = 16'h0040) (
  output logic [15:0] width_o
);
  // narrow module, so the upper width byte is held at zero
  assign width_o = {8'h00, WIDTH[7:0]};
endmodule
`default_nettype wire

// *** sim/sdram_bank_param_regs_properties.sv ***
// assertions over the bank parameter register ports
// assumes the package is compiled first; bound below
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_param_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire sdram_bank_param_pkg::cfg_req_s req_i,
  input wire logic [15:0] installed_width_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic width_match_o,
  input wire logic [7:0] cycle_tenths_o,
  input wire sdram_bank_param_pkg::bank_params_s params_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // short names for the decoded fields
  wire [7:0] cyc = params_o.min_period_at_max_latency;
  wire [15:0] dw = params_o.module_data_width;
  // a firmware write strobe at one offset
  sequence s_wr(a);
    req_i.wr_en && req_i.addr == a;
  endsequence
  property p_rv; req_i.rd_en |=> rvalid_o; endproperty
  property p_idle; !req_i.rd_en |=> !rvalid_o && rdata_o == 0; endproperty
  property p_rc;
    s_wr(8'ha4) |=> params_o.row_cycle_ns == $past(req_i.wdata[7:0]);
  endproperty
  property p_row;
    s_wr(8'hb0) |=> params_o.row_addr_bits == $past(req_i.wdata[31:28]);
  endproperty
  property p_geo;
    s_wr(8'hb4) |=> {dw, params_o.physical_bank_count,
      params_o.col_addr_bits} == $past({req_i.wdata[31:8], req_i.wdata[3:0]});
  endproperty
  property p_cyc;
    s_wr(8'hb8) |=> cyc == $past(req_i.wdata[15:8]);
  endproperty
  // stable inputs only: the flags lag their register by one cycle
  property p_match;
    $stable(dw) && !$past(rst_i) |-> width_match_o == (dw == installed_width_i);
  endproperty
  property p_ten;
    $stable(cyc) && !$past(rst_i) |-> cycle_tenths_o == cyc[7:4] * 8'h0a + cyc[3:0];
  endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  a_idle: assert property (p_idle) else $error("answer without read");
  a_rc: assert property (p_rc) else $error("row cycle not stored");
  a_row: assert property (p_row) else $error("row bits not stored");
  a_geo: assert property (p_geo) else $error("geometry wrong");
  a_cyc: assert property (p_cyc) else $error("cycle byte wrong");
  a_match: assert property (p_match) else $error("width match wrong");
  a_ten: assert property (p_ten) else $error("tenths wrong");
endmodule
bind sdram_bank_param_regs sdram_bank_param_checker chk (.*);
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the bank parameter registers
// assumes design, package, checker and module model are compiled
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdram_bank_param_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, rvalid_o, width_match_o, error_load_i = 0;
  logic [7:0] error_code_i = 8'h5a, cycle_tenths_o;
  logic [15:0] installed_width_i;
  logic [31:0] rdata_o;
  cfg_req_s req_i = '0;
  bank_params_s params_o;
  int err_total = 0, total_checks = 0;
  logic [7:0] ofs [6] = '{8'ha4, 8'ha8, 8'hb0, 8'hb4, 8'hb8, 8'hbc};
  logic [31:0] msk [6] = '{32'hff, 32'hff, 32'hf000_0000, 32'hffff_ff0f,
    32'hff00, 32'hff};
  // free-running system clock
  always #5 sys_clk_i = ~sys_clk_i;
  spd_module_model spd (.width_o(installed_width_i));
  sdram_bank_param_regs DUT (.*);
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // idle cycle after each strobe keeps drivers to one update per step
  task automatic wr(logic [7:0] a, logic [31:0] d);
    req_i <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    req_i <= '0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    req_i <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk_i);
    req_i <= '0;
    #1 chk("read", {1'b1, e}, {rvalid_o, rdata_o});
    @(posedge sys_clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // defaults, masks, unmapped place, fields, error capture
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ofs[i], i == 0 ? 32'h46 : 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], 32'hffff_ffff);
      rd(ofs[i], msk[i]);
    end
    wr(8'hc0, 32'hffff_ffff);
    rd(8'hc0, 32'h0);
    #1 chk("mismatch", 0, width_match_o);
    wr(8'hb4, 32'h0040_0209);
    wr(8'hb8, 32'h0000_7500);
    #1 chk("params", 56'hfff004002975ff, params_o);
    chk("tenths", 8'd75, cycle_tenths_o);
    chk("match", 1, width_match_o);
    @(posedge sys_clk_i);
    error_load_i <= 1'b1;
    @(posedge sys_clk_i);
    error_load_i <= 1'b0;
    rd(8'ha8, 32'h5a);
    close_out();
  end
endmodule
`default_nettype wire
